// [verilog/pdr_pkg.sv]
/*
 Constants for the pulse dialer with redial: timing, key codes, pin counts.
 Assumes a 20 MHz system clock; all times are converted to cycle counts here.
*/
package pdr_pkg;
  localparam int CLK_HZ          = 20000000;
  localparam int MEM_DEPTH       = 32;
  localparam int LINES           = 4;
  localparam int DEBOUNCE_MS     = 10;
  localparam int MUTE_OVERLAP_MS = 800;
  localparam int INTERDIGIT_MS   = 800;
  localparam int PREDIGIT_MS     = 30;
  localparam int PERIOD10_MS     = 100;
  localparam int PERIOD20_MS     = 50;
  localparam int MAKE_334_PML    = 334;
  localparam int MAKE_400_PML    = 400;
  localparam int DEBOUNCE_CYC    = (DEBOUNCE_MS * (CLK_HZ / 1000));
  localparam int OVERLAP_CYC     = (MUTE_OVERLAP_MS * (CLK_HZ / 1000));
  localparam int INTERDIGIT_CYC  = (INTERDIGIT_MS * (CLK_HZ / 1000));
  localparam int PREDIGIT_CYC    = (PREDIGIT_MS * (CLK_HZ / 1000));
  localparam int PERIOD10_CYC    = (PERIOD10_MS * (CLK_HZ / 1000));
  localparam int PERIOD20_CYC    = (PERIOD20_MS * (CLK_HZ / 1000));
  localparam int SCAN_HALF_CYC   = 4;
  localparam logic [3:0] KEY_STAR = 4'ha;
  localparam logic [3:0] KEY_HASH = 4'hb;
  localparam logic [3:0] KEY_NONE = 4'hf;
endpackage

// [verilog/pdr_pulse_dialer.sv]
/*
 Pulse dialer with 32-digit redial: keypad scan and debounce, redial memory,
 loop-disconnect outpulsing and mute control.
 Assumes keypad, hook and select inputs synchronous to clock; open-drain pins
 are resolved outside from the enables (enable high pulls the line low).
*/
// Function
// - Redial memory holds up to 32 digits.
// - Valid key: one row with one column, or ground on one row and column; the code senses only the ground case.
// - On-hook: keypad lines held high, keys ignored.
// - Off-hook: static lines until key sensed, then alternate row/column scan.
// - Key accepted only after 10 ms of continuous validity.
// - Dial rate 10 or 20 pps from rate select.
// - Make/break 33.4/66.6 with select high, 40/60 with select low.
// - Pulse output released during make, pulled low during break.
// - Mute pulls low at predigital pause, releases after final break.
// - Mute held for overlap delay, 800 ms, after last break; the code starts it only after the final make and the interdigit pause.
// - Hook low means off-hook, high means on-hook.
// - Going on-hook finishes current outpulsing, then goes idle.
// - Returning off-hook gives a falling mute edge.
// - First key star or hash redials stored number.
// - Other first key clears memory, stores and dials new digits.
// - Control state cleared at power-up without external reset; the code clears it only on the synchronous sys_rst.
`timescale 1ns/1ps
module pdr_pulse_dialer #(
  parameter int DEBOUNCE_CYC   = pdr_pkg::DEBOUNCE_CYC,
  parameter int OVERLAP_CYC    = pdr_pkg::OVERLAP_CYC,
  parameter int INTERDIGIT_CYC = pdr_pkg::INTERDIGIT_CYC,
  parameter int PREDIGIT_CYC   = pdr_pkg::PREDIGIT_CYC,
  parameter int PERIOD10_CYC   = pdr_pkg::PERIOD10_CYC,
  parameter int PERIOD20_CYC   = pdr_pkg::PERIOD20_CYC
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       sys_rst,
  // Hook and selects
  input  wire logic       hook_sense,
  input  wire logic       rateSelect,
  input  wire logic       ratioSelect,
  // Keypad, open-drain style
  input  wire logic [3:0] keypad_horizontal_lines_in,
  output logic      [3:0] keypad_horizontal_lines_out,
  output logic      [3:0] keypad_horizontal_lines_oe,
  input  wire logic [3:0] keypad_vertical_lines_in,
  output logic      [3:0] keypad_vertical_lines_out,
  output logic      [3:0] keypad_vertical_lines_oe,
  // Line outputs, open drain
  output logic            pulseOut,
  output logic            pulseOe,
  output logic            muteOut,
  output logic            muteOe,
  // Status
  output logic            oscRun
);

  typedef enum logic [5:0] {
    PDR_IDLE   = 6'b000001,
    PDR_PRE    = 6'b000010,
    PDR_MAKE   = 6'b000100,
    PDR_BREAK  = 6'b001000,
    PDR_GAP    = 6'b010000,
    PDR_DRAIN  = 6'b100000
  } pdr_state_e;

  // Exactly one low bit; returns its index or none
  function automatic logic [2:0] pdr_onehot_low(input logic [3:0] v);
    logic [2:0] r;
    r = 3'h4;
    case (v)
      4'he:    r = 3'h0;
      4'hd:    r = 3'h1;
      4'hb:    r = 3'h2;
      4'h7:    r = 3'h3;
      default: r = 3'h4;
    endcase
    return r;
  endfunction

  // Star and hash both mean redial
  function automatic logic pdr_is_redial(input logic [3:0] k);
    return (k == pdr_pkg::KEY_STAR) || (k == pdr_pkg::KEY_HASH);
  endfunction

  pdr_state_e state;
  pdr_state_e next_state;
  logic        offHook;
  logic        hookPrev;
  logic        firstKey;
  logic        scanning;
  logic        scanPhase;
  logic [2:0]  scanCnt;
  logic [2:0]  rowIdx;
  logic [2:0]  colIdx;
  logic [2:0]  rowSeen;
  logic [2:0]  colSeen;
  logic [2:0]  rowEff;
  logic [2:0]  colEff;
  logic        keyValid;
  logic [3:0]  rawKey;
  logic [3:0]  heldKey;
  logic [31:0] debCnt;
  logic        keyDone;
  logic        accept;
  logic [3:0]  acceptKey;
  logic [3:0]  mem [pdr_pkg::MEM_DEPTH];
  logic [5:0]  wrPtr;
  logic [5:0]  rdPtr;
  logic [3:0]  breaksLeft;
  logic [31:0] tmr;
  logic [31:0] period;
  logic [31:0] makeLen;
  logic        muteOn;
  logic        wantDial;
  logic        haveDigit;

  assign offHook = ~hook_sense;

  // Keypad drive: lines released until a key is sensed; the scan then alternates which group
  // is pulled low; only a form A contact (ground) is sensed on the released lines, so a matrix short never starts it.
  always_comb
  begin
    keypad_horizontal_lines_out = 4'h0;
    keypad_vertical_lines_out   = 4'h0;
    keypad_horizontal_lines_oe  = 4'h0;
    keypad_vertical_lines_oe    = 4'h0;
    if (offHook && scanning && scanPhase)
      keypad_horizontal_lines_oe = 4'hf;
    else if (offHook && scanning && !scanPhase)
      keypad_vertical_lines_oe = 4'hf;
  end

  assign rowIdx   = pdr_onehot_low(keypad_horizontal_lines_in);
  assign colIdx   = pdr_onehot_low(keypad_vertical_lines_in);
  // Driven group reads back all low, so its latched index stands in
  assign rowEff   = (scanning && scanPhase) ? rowSeen : rowIdx;
  assign colEff   = (scanning && !scanPhase) ? colSeen : colIdx;
  // Both groups low on one line each: one row to one column or ground
  assign keyValid = offHook && (rowEff != 3'h4) && (colEff != 3'h4);
  assign rawKey   = {rowEff[1:0], colEff[1:0]};
  assign oscRun   = scanning || (state != PDR_IDLE);

  // Scanner only runs once a key is sensed, to keep lines static otherwise
  always_ff @(posedge clock)
  begin
    if (sys_rst || !offHook)
    begin
      scanning  <= 1'b0;
      scanPhase <= 1'b0;
      scanCnt   <= 3'h0;
    end
    else if (!scanning && keyValid)
      scanning <= 1'b1;
    // Stop once the key lifts, accepted or not, so a bounce too short to
    // count does not leave the oscillator running
    else if (scanning && !keyValid)
      scanning <= 1'b0;
    else if (scanning)
    begin
      scanCnt <= 3'((32'(scanCnt) + 1) % pdr_pkg::SCAN_HALF_CYC);
      if (scanCnt == 3'(pdr_pkg::SCAN_HALF_CYC - 1))
        scanPhase <= ~scanPhase;
    end
  end

  // Pulling a whole group low hides which of its lines the key holds,
  // so that group keeps the index seen while it was still undriven
  always_ff @(posedge clock)
  begin
    if (sys_rst || !scanning)
    begin
      rowSeen <= rowIdx;
      colSeen <= colIdx;
    end
    else if (scanPhase)
      colSeen <= colIdx;
    else
      rowSeen <= rowIdx;
  end

  // Debounce: key must hold unchanged for the full interval
  // A new key restarts the count, so a rolled key is never half-timed
  always_ff @(posedge clock)
  begin
    accept <= 1'b0;
    if (sys_rst || !offHook)
    begin
      debCnt  <= 32'h0;
      heldKey <= pdr_pkg::KEY_NONE;
      keyDone <= 1'b0;
    end
    else if (!keyValid)
    begin
      debCnt  <= 32'h0;
      heldKey <= pdr_pkg::KEY_NONE;
      keyDone <= 1'b0;
    end
    else if (rawKey != heldKey)
    begin
      heldKey <= rawKey;
      debCnt  <= 32'h1;
      keyDone <= 1'b0;
    end
    else if (!keyDone && debCnt >= 32'(DEBOUNCE_CYC - 1))
    begin
      keyDone   <= 1'b1;
      accept    <= 1'b1;
      acceptKey <= heldKey;
    end
    else if (!keyDone)
      debCnt <= debCnt + 32'h1;
  end

  // Memory: first key decides redial or new number; later digit keys queue, later star or hash is ignored
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      wrPtr    <= 6'h0;
      firstKey <= 1'b1;
      hookPrev <= 1'b1;
      wantDial <= 1'b0;
    end
    else
    begin
      hookPrev <= hook_sense;
      if (!offHook)
        firstKey <= 1'b1;
      if (accept && firstKey)
      begin
        firstKey <= 1'b0;
        if (pdr_is_redial(acceptKey))
          wantDial <= 1'b1;
        else
        begin
          mem[0]   <= acceptKey;
          wrPtr    <= 6'h1;
          wantDial <= 1'b1;
        end
      end
      // Digits beyond the last slot are dropped; the stored ones stay intact
      else if (accept && !pdr_is_redial(acceptKey)
               && wrPtr < 6'(pdr_pkg::MEM_DEPTH))
      begin
        mem[wrPtr[4:0]] <= acceptKey;
        wrPtr           <= wrPtr + 6'h1;
      end
      else if (state != PDR_IDLE)
        wantDial <= 1'b0;
    end
  end

  assign haveDigit = (rdPtr < wrPtr);
  // Rate and ratio are read live; a change mid-digit bends one pulse
  assign period    = rateSelect ? 32'(PERIOD20_CYC) : 32'(PERIOD10_CYC);
  // Make share in per-mille of the period
  assign makeLen   = ratioSelect ?
                     32'((64'(period) * pdr_pkg::MAKE_334_PML) / 1000) :
                     32'((64'(period) * pdr_pkg::MAKE_400_PML) / 1000);

  // Digits keyed after a number has finished dial on from where it stopped
  always_comb
  begin
    next_state = state;
    case (state)
      PDR_IDLE:  if (offHook && (wantDial || (haveDigit && !firstKey)))
                   next_state = PDR_PRE;
      PDR_PRE:   if (tmr == 32'h0) next_state = haveDigit ? PDR_BREAK : PDR_DRAIN;
      PDR_BREAK: if (tmr == 32'h0) next_state = PDR_MAKE;
      PDR_MAKE:  if (tmr == 32'h0) next_state = (breaksLeft != 4'h0) ? PDR_BREAK : PDR_GAP;
      PDR_GAP:   if (tmr == 32'h0)
                   next_state = (haveDigit && offHook) ? PDR_BREAK : PDR_DRAIN;
      PDR_DRAIN: if (tmr == 32'h0) next_state = PDR_IDLE;
      default:   next_state = PDR_IDLE;
    endcase
  end

  // Outpulsing sequencer and its timer
  // Each state but idle loads its length on entry and counts down to zero
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state      <= PDR_IDLE;
      tmr        <= 32'h0;
      rdPtr      <= 6'h0;
      breaksLeft <= 4'h0;
    end
    else
    begin
      state <= next_state;
      if (tmr != 32'h0 && next_state == state)
        tmr <= tmr - 32'h1;
      case (next_state)
        PDR_PRE:   if (state != PDR_PRE)
                   begin
                     tmr   <= 32'(PREDIGIT_CYC - 1);
                     if (wantDial)
                       rdPtr <= 6'h0;
                   end
        PDR_BREAK: if (state != PDR_BREAK)
                   begin
                     tmr <= period - makeLen - 32'h1;
                     if (state != PDR_MAKE)
                     begin
                       // Digit zero is ten breaks
                       breaksLeft <= (mem[rdPtr[4:0]] == 4'h0) ? 4'h9 :
                                     mem[rdPtr[4:0]] - 4'h1;
                       rdPtr      <= rdPtr + 6'h1;
                     end
                     else
                       breaksLeft <= breaksLeft - 4'h1;
                   end
        PDR_MAKE:  if (state != PDR_MAKE) tmr <= makeLen - 32'h1;
        PDR_GAP:   if (state != PDR_GAP) tmr <= 32'(INTERDIGIT_CYC - 1);
        PDR_DRAIN: if (state != PDR_DRAIN) tmr <= 32'(OVERLAP_CYC - 1);
        default:   ;
      endcase
    end
  end

  // Mute: on for the whole sequence plus overlap; a fresh off-hook
  // pulls it at once from the released on-hook level, giving the network a falling edge.
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      muteOn <= 1'b0;
    else if (offHook && hookPrev)
      muteOn <= 1'b1;
    else if (next_state == PDR_PRE)
      muteOn <= 1'b1;
    else if (state == PDR_DRAIN && next_state == PDR_IDLE)
      muteOn <= 1'b0;
    else if (state == PDR_IDLE && !wantDial && !offHook)
      muteOn <= 1'b0;
  end

  // Open-drain pins: level always low, the enable does the work
  assign muteOut  = 1'b0;
  assign muteOe   = muteOn;
  assign pulseOut = 1'b0;
  assign pulseOe  = (state == PDR_BREAK);

endmodule // pdr_pulse_dialer

// [verif/pdr_pulse_dialer_properties.sv]
/* Pin-level assertions for the pulse dialer.
 Assumes a bind onto pdr_pulse_dialer and selects held steady while dialing. */
`timescale 1ns/1ps
module pdr_pulse_dialer_properties #(
  parameter int OVERLAP_CYC  = 20,
  parameter int PERIOD10_CYC = 50,
  parameter int PERIOD20_CYC = 40
) (
  // Clock, reset, controls
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       hook_sense,
  input wire logic       rateSelect,
  input wire logic       ratioSelect,
  // Enables and oscillator status
  input wire logic [3:0] keypad_horizontal_lines_oe,
  input wire logic [3:0] keypad_vertical_lines_oe,
  input wire logic       pulseOe,
  input wire logic       muteOe,
  input wire logic       oscRun
);
  int brk;
  int gap;
  int per;
  int mk;
  // Run lengths of break and of released line
  always_ff @(posedge clock) brk <= (sys_rst || !pulseOe) ? 0 : brk + 1;
  always_ff @(posedge clock) gap <= (sys_rst || pulseOe) ? 0 : gap + 1;
  assign per = rateSelect ? PERIOD20_CYC : PERIOD10_CYC;
  assign mk  = per * (ratioSelect ? 334 : 400) / 1000;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  a_reset_quiet: assert property ($fell(sys_rst) |->
    !pulseOe && !muteOe && !oscRun) else $error("outputs active after reset");
  a_onhook_static: assert property ($past(hook_sense) && hook_sense |->
    keypad_horizontal_lines_oe == 4'h0 && keypad_vertical_lines_oe == 4'h0)
    else $error("keypad driven on hook");
  a_scan_alternate: assert property (|keypad_horizontal_lines_oe |->
    keypad_vertical_lines_oe == 4'h0 && oscRun) else $error("rows and columns together");
  a_break_muted: assert property (pulseOe |-> muteOe)
    else $error("break without mute");
  a_break_len: assert property ($fell(pulseOe) |-> brk == per - mk)
    else $error("break length wrong");
  // Predigit and interdigit gaps fall outside this window
  a_make_len: assert property ($rose(pulseOe) && gap > per / 4 && gap < per |->
    gap == mk) else $error("make length wrong");
  a_mute_hold: assert property ($fell(muteOe) |->
    !pulseOe && gap >= OVERLAP_CYC) else $error("mute released early");
  a_offhook_mute: assert property ($fell(hook_sense) |-> ##[0:4] muteOe)
    else $error("no mute edge off hook");
  c_break_fast: cover property (rateSelect && $rose(pulseOe));
  c_break_slow: cover property (!rateSelect && $rose(pulseOe));
  c_mute_off: cover property ($fell(muteOe));
endmodule // pdr_pulse_dialer_properties

bind pdr_pulse_dialer pdr_pulse_dialer_properties #(.OVERLAP_CYC(OVERLAP_CYC),
  .PERIOD10_CYC(PERIOD10_CYC), .PERIOD20_CYC(PERIOD20_CYC)) u_props (
  .clock(clock), .sys_rst(sys_rst), .hook_sense(hook_sense), .rateSelect(rateSelect),
  .ratioSelect(ratioSelect), .keypad_horizontal_lines_oe(keypad_horizontal_lines_oe),
  .keypad_vertical_lines_oe(keypad_vertical_lines_oe), .pulseOe(pulseOe),
  .muteOe(muteOe), .oscRun(oscRun));

// [verif/pdr_keypad_line.sv]
/* Keypad contact and line transistors facing the dialer.
 Assumes a grounding single-contact key and pull-ups on every line. */
`timescale 1ns/1ps
module pdr_keypad_line (
  // Key from bench
  input  wire logic       keyDown,
  input  wire logic [3:0] keyCode,
  // Dialer enables
  input  wire logic [3:0] rowOe,
  input  wire logic [3:0] colOe,
  input  wire logic       pulseOe,
  input  wire logic       muteOe,
  // Resolved lines
  output logic      [3:0] rowIn,
  output logic      [3:0] colIn,
  output logic            pulseLine,
  output logic            muteLine
);
  // Key grounds one row and one column; scan pulls add on top
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      rowIn[i] = !(rowOe[i] || (keyDown && keyCode[3:2] == i));
      colIn[i] = !(colOe[i] || (keyDown && keyCode[1:0] == i));
    end
  end
  assign pulseLine = !pulseOe;
  assign muteLine  = !muteOe;
endmodule // pdr_keypad_line

// [verif/pdr_pulse_dialer_bench.sv]
/* Self-checking bench for the pulse dialer.
 Assumes the keypad and line model and the bound checker; timings shortened. */
`timescale 1ns/1ps
module pdr_pulse_dialer_bench;
  logic       clock       = 1'b0;
  logic       sys_rst     = 1'b1;
  logic       hook_sense  = 1'b1;
  logic       rateSelect  = 1'b0;
  logic       ratioSelect = 1'b1;
  logic       keyDown     = 1'b0;
  logic [3:0] keyCode     = 4'h0;
  logic [3:0] rowIn;
  logic [3:0] colIn;
  logic [3:0] rowOe;
  logic [3:0] colOe;
  logic       pulseOe;
  logic       muteOe;
  logic       oscRun;
  logic       pulseLine;
  logic       muteLine;
  logic [3:0] rowOut;
  logic [3:0] colOut;
  logic       pulsePin;
  logic       mutePin;
  int         mismatches  = 0;
  int         check_count = 0;

  pdr_pulse_dialer #(.DEBOUNCE_CYC(8), .OVERLAP_CYC(20), .INTERDIGIT_CYC(1200),
    .PREDIGIT_CYC(5), .PERIOD10_CYC(1000), .PERIOD20_CYC(500)) u_pdr_pulse_dialer (
    .clock(clock), .sys_rst(sys_rst), .hook_sense(hook_sense), .rateSelect(rateSelect),
    .ratioSelect(ratioSelect), .keypad_horizontal_lines_in(rowIn),
    .keypad_horizontal_lines_out(rowOut), .keypad_horizontal_lines_oe(rowOe),
    .keypad_vertical_lines_in(colIn), .keypad_vertical_lines_out(colOut),
    .keypad_vertical_lines_oe(colOe), .pulseOut(pulsePin), .pulseOe(pulseOe),
    .muteOut(mutePin),
    .muteOe(muteOe), .oscRun(oscRun));

  pdr_keypad_line u_pdr_keypad_line (.keyDown(keyDown), .keyCode(keyCode), .rowOe(rowOe),
    .colOe(colOe), .pulseOe(pulseOe), .muteOe(muteOe), .rowIn(rowIn), .colIn(colIn),
    .pulseLine(pulseLine), .muteLine(muteLine));

  initial forever #25 clock = ~clock;

  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic check_bit(string what, logic exp, logic got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_num(string what, int exp, int got);
    check_count++;
    if (got != exp)
    begin
      mismatches++;
      $display("FAIL %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic press(logic [3:0] code, int hold);
    keyCode = code;
    keyDown = 1'b1;
    cyc(hold);
    keyDown = 1'b0;
    cyc(4);
  endtask

  // Counts breaks until the line rests longer than any make
  task automatic expect_digit(int exp);
    int n;
    int quiet;
    n = 0;
    quiet = 1;
    while (quiet < (n == 0 ? 3000 : 1100))
    begin
      cyc(1);
      if (pulseLine)
        quiet++;
      else
      begin
        if (quiet > 0)
          n++;
        quiet = 0;
      end
    end
    check_num("breaks in digit", exp, n);
  endtask

  task automatic hang_up;
    hook_sense = 1'b1;
    cyc(2000);
    check_bit("mute line on hook", 1'b1, muteLine);
    check_bit("oscillator idle", 1'b0, oscRun);
    check_bit("pulse pin level", 1'b0, pulsePin);
    check_bit("mute pin level", 1'b0, mutePin);
    check_bit("keypad drive level", 1'b0, |{rowOut, colOut});
  endtask

  task automatic t_onhook_keys;
    keyCode = 4'h3;
    keyDown = 1'b1;
    cyc(40);
    check_bit("oscillator on hook", 1'b0, oscRun);
    check_bit("rows on hook", 1'b0, |rowOe);
    keyDown = 1'b0;
    expect_digit(0);
  endtask

  task automatic t_short_then_new;
    hook_sense = 1'b0;
    cyc(6);
    check_bit("mute line off hook", 1'b0, muteLine);
    press(4'h3, 5);
    expect_digit(0);
    press(4'h3, 20);
    press(4'h5, 20);
    expect_digit(3);
    expect_digit(5);
    hang_up();
  endtask

  // Short cut keys at the other three rate and ratio pairs; a new number only at the fast rate with 33.4/66.6
  task automatic t_call(logic [3:0] code, logic fast, logic third, int d1, int d2);
    rateSelect = fast;
    ratioSelect = third;
    hook_sense = 1'b0;
    cyc(6);
    press(code, 20);
    expect_digit(d1);
    expect_digit(d2);
    hang_up();
  endtask

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #(50 * 90000);
    mismatches++;
    conclude();
  end

  initial
  begin
    cyc(16);
    sys_rst = 1'b0;
    cyc(1);
    check_bit("pulse enable", 1'b0, pulseOe);
    check_bit("mute enable", 1'b0, muteOe);
    t_onhook_keys();
    t_short_then_new();
    t_call(pdr_pkg::KEY_STAR, 1'b1, 1'b0, 3, 5);
    t_call(pdr_pkg::KEY_HASH, 1'b0, 1'b1, 3, 5);
    t_call(4'h0, 1'b1, 1'b1, 10, 0);
    t_call(pdr_pkg::KEY_STAR, 1'b0, 1'b0, 10, 0);
    conclude();
  end
endmodule // pdr_pulse_dialer_bench
